/* apm_pkg.sv */
package apm_pkg;

    // ****************************************
    // Pin indices within the group
    // ****************************************
    localparam int PIN_COUNT = 6;
    localparam int PIN_DOUT3 = 0;
    localparam int PIN_DOUT2 = 1;
    localparam int PIN_DIN2  = 2;
    localparam int PIN_DIN3  = 3;
    localparam int PIN_HCKR  = 4;
    localparam int PIN_HCKT  = 5;

    // ****************************************
    // Register map
    // ****************************************
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_PINMUX     = 8'h04;
    localparam logic [7:0]  OFF_SPD_PHASE  = 8'h08;
    localparam logic [7:0]  OFF_GPIO_DIR   = 8'h0C;
    localparam logic [7:0]  OFF_GPIO_OUT   = 8'h10;
    localparam logic [7:0]  OFF_GPIO_IN    = 8'h14;
    localparam logic [7:0]  OFF_ROLE       = 8'h18;

    // ****************************************
    // Field positions and widths
    // ****************************************
    localparam int CTRL_W        = 5;
    localparam int CTRL_P2_TX    = 0;
    localparam int CTRL_P2_RX    = 1;
    localparam int CTRL_P3_EN    = 2;
    localparam int CTRL_HCKR_OUT = 3;
    localparam int CTRL_HCKT_OUT = 4;

    localparam int PMX_W          = 4;
    localparam int PMX_SPD_OUT_EN = 0;
    localparam int PMX_SPD_IN1_EN = 1;
    localparam int PMX_RCS_LSB    = 2;
    localparam int SEL_W          = 2;
    localparam logic [1:0] RCS_SPD = 2'h1;

    localparam int TCS_LSB         = 0;
    localparam logic [1:0] TCS_PIN = 2'h1;

    localparam int MODE_W = 2;
    localparam int ROLE_W = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [4:0]  RST_CTRL      = 5'h00;
    localparam logic [3:0]  RST_PINMUX    = 4'h0;
    localparam logic [1:0]  RST_SPD_PHASE = 2'h0;
    localparam logic [11:0] RST_GPIO_DIR  = 12'h000;
    localparam logic [5:0]  RST_GPIO_OUT  = 6'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0]
    {
        APM_ROLE_GPIO = 3'h1,
        APM_ROLE_PORT = 3'h2,
        APM_ROLE_ALT  = 3'h4
    } apm_role_t;

    typedef enum logic [1:0]
    {
        APM_GPIO_DISC = 2'h0,
        APM_GPIO_IN   = 2'h1,
        APM_GPIO_OUT  = 2'h2
    } apm_gpio_mode_t;

endpackage

/* apm_sync.sv */
`timescale 1ns/100ps
module apm_sync
#(
    parameter int WIDTH = 6
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import apm_pkg::*;

    logic [WIDTH-1:0] stage1;

    generate
        if (WIDTH < 1)
        begin : g_chk
            $error("apm_sync width must be at least one");
        end
    endgenerate

    // ****************************************
    // Two-flop synchroniser
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* apm_pin_cell.sv */
`timescale 1ns/100ps
module apm_pin_cell
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire apm_pkg::apm_role_t      role,
    input  wire logic                    port_out,
    input  wire logic                    port_oe,
    input  wire logic                    alt_out,
    input  wire logic                    alt_oe,
    input  wire apm_pkg::apm_gpio_mode_t gpio_mode,
    input  wire logic                    gpio_out,
    output logic                         pin_out,
    output logic                         pin_oe
);
    import apm_pkg::*;

    // ****************************************
    // Registered pad drive, alternate first
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end
        else
        begin
            case (role)
                APM_ROLE_ALT:
                begin
                    pin_out <= alt_out;
                    pin_oe  <= alt_oe;
                end
                APM_ROLE_PORT:
                begin
                    pin_out <= port_out;
                    pin_oe  <= port_oe;
                end
                APM_ROLE_GPIO:
                begin
                    pin_out <= (gpio_mode == APM_GPIO_OUT) ? gpio_out : 1'b0;
                    pin_oe  <= (gpio_mode == APM_GPIO_OUT);
                end
                default:
                begin
                    pin_out <= 1'b0;
                    pin_oe  <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* apm_audio_pin_mux.sv */
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module apm_audio_pin_mux
#(
    parameter bit SMALL_PKG = 1'b1
)
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [apm_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [apm_pkg::PIN_COUNT-1:0]   pin_in,
    output logic      [apm_pkg::PIN_COUNT-1:0]   pin_out,
    output logic      [apm_pkg::PIN_COUNT-1:0]   pin_oe,
    input  wire logic                            tx_shift_reg_3_bit,
    input  wire logic                            tx_shift_reg_2_bit,
    output logic                                 rx_shift_reg_2_bit,
    output logic                                 rx_shift_reg_3_bit,
    input  wire logic                            port3_rx_hf_clk_src,
    input  wire logic                            port3_tx_hf_clk_src,
    output logic                                 port3_rx_clk_use_pin,
    output logic                                 port3_rx_ext_clk,
    output logic                                 port3_tx_clk_use_pin,
    output logic                                 port3_tx_ext_clk,
    input  wire logic                            spd_output_line1,
    output logic                                 spd_input_line1,
    input  wire logic                            spd_rx_clock_out,
    output logic                                 spd_tx_clock_in
);
    import apm_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic [CTRL_W-1:0]           ctrl;
    logic [PMX_W-1:0]            pinmux;
    logic [SEL_W-1:0]            spd_phase;
    logic [2*PIN_COUNT-1:0]      gpio_dir;
    logic [PIN_COUNT-1:0]        gpio_out;
    logic [PIN_COUNT-1:0]        pin_sync;
    logic [PIN_COUNT-1:0]        alt_sel;
    logic [PIN_COUNT-1:0]        alt_out;
    logic [PIN_COUNT-1:0]        alt_oe;
    logic [PIN_COUNT-1:0]        port_sel;
    logic [PIN_COUNT-1:0]        port_out;
    logic [PIN_COUNT-1:0]        port_oe;
    logic [PIN_COUNT-1:0]        gpio_in_now;
    apm_role_t                   role [PIN_COUNT];
    logic [ROLE_W*PIN_COUNT-1:0] role_flat;
    logic                        rcs_pick;
    logic                        tcs_pick;
    logic                        setup;
    logic                        wr_access;

    generate
        if (PIN_COUNT != 6)
        begin : g_chk
            $error("apm_audio_pin_mux serves exactly six pins");
        end
    endgenerate

    // ****************************************
    // Helpers
    // ****************************************
    function automatic apm_role_t pick_role(input logic alt, input logic port);
        return alt ? APM_ROLE_ALT : (port ? APM_ROLE_PORT : APM_ROLE_GPIO);
    endfunction

    function automatic apm_gpio_mode_t pin_mode(input logic [2*PIN_COUNT-1:0] dir, input int idx);
        logic [MODE_W-1:0] raw;
        raw = dir[idx*MODE_W +: MODE_W];
        return (raw == APM_GPIO_IN || raw == APM_GPIO_OUT) ? apm_gpio_mode_t'(raw) : APM_GPIO_DISC;
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_PINMUX) || (a == OFF_SPD_PHASE) ||
               (a == OFF_GPIO_DIR) || (a == OFF_GPIO_OUT) || (a == OFF_GPIO_IN) ||
               (a == OFF_ROLE);
    endfunction

    // ****************************************
    // APB slave: registers and zero-wait answer
    // ****************************************
    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl      <= RST_CTRL;
            pinmux    <= RST_PINMUX;
            spd_phase <= RST_SPD_PHASE;
            gpio_dir  <= RST_GPIO_DIR;
            gpio_out  <= RST_GPIO_OUT;
        end
        else if (wr_access)
        begin
            case (paddr)
                OFF_CTRL:      ctrl      <= pwdata[CTRL_W-1:0];
                OFF_PINMUX:    pinmux    <= pwdata[PMX_W-1:0];
                OFF_SPD_PHASE: spd_phase <= pwdata[TCS_LSB +: SEL_W];
                OFF_GPIO_DIR:  gpio_dir  <= pwdata[2*PIN_COUNT-1:0];
                OFF_GPIO_OUT:  gpio_out  <= pwdata[PIN_COUNT-1:0];
                default:       ctrl      <= ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !addr_known(paddr);
            prdata  <= 32'h00000000;
            if (setup && !pwrite)
            begin
                case (paddr)
                    OFF_CTRL:      prdata <= {27'h0000000, ctrl};
                    OFF_PINMUX:    prdata <= {28'h0000000, pinmux};
                    OFF_SPD_PHASE: prdata <= {30'h00000000, spd_phase};
                    OFF_GPIO_DIR:  prdata <= {20'h00000, gpio_dir};
                    OFF_GPIO_OUT:  prdata <= {26'h0000000, gpio_out};
                    OFF_GPIO_IN:   prdata <= {26'h0000000, gpio_in_now};
                    OFF_ROLE:      prdata <= {14'h0000, role_flat};
                    default:       prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Pad input synchroniser
    // ****************************************
    apm_sync #(.WIDTH(PIN_COUNT)) u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // ****************************************
    // Function selection per pin
    // ****************************************
    assign rcs_pick = (pinmux[PMX_RCS_LSB +: SEL_W] == RCS_SPD);
    assign tcs_pick = (spd_phase == TCS_PIN);

    always_comb
    begin
        alt_sel = '0;
        alt_out = '0;
        alt_oe  = '0;
        alt_sel[PIN_DOUT3] = SMALL_PKG && pinmux[PMX_SPD_OUT_EN];
        alt_out[PIN_DOUT3] = spd_output_line1;
        alt_oe[PIN_DOUT3]  = 1'b1;
        alt_sel[PIN_DOUT2] = SMALL_PKG && pinmux[PMX_SPD_IN1_EN];
        alt_sel[PIN_HCKR]  = rcs_pick;
        alt_out[PIN_HCKR]  = spd_rx_clock_out;
        alt_oe[PIN_HCKR]   = 1'b1;
        alt_sel[PIN_HCKT]  = tcs_pick;
    end

    always_comb
    begin
        port_sel = '0;
        port_out = '0;
        port_oe  = '0;
        port_sel[PIN_DOUT3] = ctrl[CTRL_P2_TX];
        port_out[PIN_DOUT3] = tx_shift_reg_3_bit;
        port_oe[PIN_DOUT3]  = 1'b1;
        port_sel[PIN_DOUT2] = ctrl[CTRL_P2_TX];
        port_out[PIN_DOUT2] = tx_shift_reg_2_bit;
        port_oe[PIN_DOUT2]  = 1'b1;
        port_sel[PIN_DIN2]  = ctrl[CTRL_P2_RX];
        port_sel[PIN_DIN3]  = ctrl[CTRL_P2_RX];
        port_sel[PIN_HCKR]  = ctrl[CTRL_P3_EN];
        port_out[PIN_HCKR]  = port3_rx_hf_clk_src;
        port_oe[PIN_HCKR]   = ctrl[CTRL_HCKR_OUT];
        port_sel[PIN_HCKT]  = ctrl[CTRL_P3_EN];
        port_out[PIN_HCKT]  = port3_tx_hf_clk_src;
        port_oe[PIN_HCKT]   = ctrl[CTRL_HCKT_OUT];
    end

    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            role[i] = pick_role(alt_sel[i], port_sel[i]);
            role_flat[i*ROLE_W +: ROLE_W] = role[i];
            gpio_in_now[i] = (role[i] == APM_ROLE_GPIO) &&
                             (pin_mode(gpio_dir, i) == APM_GPIO_IN) && pin_sync[i];
        end
    end

    // ****************************************
    // Pad drive cells
    // ****************************************
    generate
        for (genvar g = 0; g < PIN_COUNT; g++)
        begin : g_pin
            apm_pin_cell u_cell
            (
                .pclk      (pclk),
                .presetn   (presetn),
                .role      (role[g]),
                .port_out  (port_out[g]),
                .port_oe   (port_oe[g]),
                .alt_out   (alt_out[g]),
                .alt_oe    (alt_oe[g]),
                .gpio_mode (pin_mode(gpio_dir, g)),
                .gpio_out  (gpio_out[g]),
                .pin_out   (pin_out[g]),
                .pin_oe    (pin_oe[g])
            );
        end
    endgenerate

    // ****************************************
    // Inbound routing to the core
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_shift_reg_2_bit   <= 1'b0;
            rx_shift_reg_3_bit   <= 1'b0;
            port3_rx_clk_use_pin <= 1'b0;
            port3_rx_ext_clk     <= 1'b0;
            port3_tx_clk_use_pin <= 1'b0;
            port3_tx_ext_clk     <= 1'b0;
            spd_input_line1      <= 1'b0;
            spd_tx_clock_in      <= 1'b0;
        end
        else
        begin
            rx_shift_reg_2_bit <= (role[PIN_DIN2] == APM_ROLE_PORT) && pin_sync[PIN_DIN2];
            rx_shift_reg_3_bit <= (role[PIN_DIN3] == APM_ROLE_PORT) && pin_sync[PIN_DIN3];
            port3_rx_clk_use_pin <= (role[PIN_HCKR] == APM_ROLE_PORT) && !ctrl[CTRL_HCKR_OUT];
            port3_rx_ext_clk <= (role[PIN_HCKR] == APM_ROLE_PORT) && !ctrl[CTRL_HCKR_OUT] &&
                                pin_sync[PIN_HCKR];
            port3_tx_clk_use_pin <= (role[PIN_HCKT] == APM_ROLE_PORT) && !ctrl[CTRL_HCKT_OUT];
            port3_tx_ext_clk <= (role[PIN_HCKT] == APM_ROLE_PORT) && !ctrl[CTRL_HCKT_OUT] &&
                                pin_sync[PIN_HCKT];
            spd_input_line1 <= alt_sel[PIN_DOUT2] && pin_sync[PIN_DOUT2];
            spd_tx_clock_in <= alt_sel[PIN_HCKT] && pin_sync[PIN_HCKT];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_tx_lanes;
        (ctrl[CTRL_P2_TX] && !alt_sel[PIN_DOUT3]) |=>
            pin_oe[PIN_DOUT3] && (pin_out[PIN_DOUT3] == $past(tx_shift_reg_3_bit)) &&
            ($past(alt_sel[PIN_DOUT2]) || (pin_oe[PIN_DOUT2] && pin_out[PIN_DOUT2] == $past(tx_shift_reg_2_bit)));
    endproperty
    a_tx_lanes: assert property (p_tx_lanes) else $error("tx lane pins not driven from shift bits");
    property p_rx_lanes;
        ctrl[CTRL_P2_RX] |=> !pin_oe[PIN_DIN2] && !pin_oe[PIN_DIN3] &&
            (rx_shift_reg_2_bit == $past(pin_sync[PIN_DIN2])) && (rx_shift_reg_3_bit == $past(pin_sync[PIN_DIN3]));
    endproperty
    a_rx_lanes: assert property (p_rx_lanes) else $error("rx lanes not fed from pins");
    property p_gpio_out;
        (role[PIN_DIN2] == APM_ROLE_GPIO && pin_mode(gpio_dir, PIN_DIN2) == APM_GPIO_OUT) |=>
            pin_oe[PIN_DIN2] && (pin_out[PIN_DIN2] == $past(gpio_out[PIN_DIN2]));
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("gpio output pin not driven");
    property p_gpio_disc;
        (role[PIN_DIN3] == APM_ROLE_GPIO && pin_mode(gpio_dir, PIN_DIN3) != APM_GPIO_OUT) |=>
            !pin_oe[PIN_DIN3] ##1 (pin_mode(gpio_dir, PIN_DIN3) != APM_GPIO_DISC || !gpio_in_now[PIN_DIN3]);
    endproperty
    a_gpio_disc: assert property (p_gpio_disc) else $error("disconnected gpio pin active");
    property p_reset_state;
        (ctrl == RST_CTRL && pinmux == RST_PINMUX && spd_phase == RST_SPD_PHASE &&
         gpio_dir == RST_GPIO_DIR) |=> (pin_oe == '0) && !rx_shift_reg_2_bit && !spd_tx_clock_in;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("pins active in reset configuration");
    property p_spd_out;
        (SMALL_PKG && pinmux[PMX_SPD_OUT_EN]) |=>
            pin_oe[PIN_DOUT3] && (pin_out[PIN_DOUT3] == $past(spd_output_line1));
    endproperty
    a_spd_out: assert property (p_spd_out) else $error("S/PDIF output not on lane 3 pin");
    property p_spd_in;
        (SMALL_PKG && pinmux[PMX_SPD_IN1_EN]) |=>
            !pin_oe[PIN_DOUT2] && (spd_input_line1 == $past(pin_sync[PIN_DOUT2]));
    endproperty
    a_spd_in: assert property (p_spd_in) else $error("S/PDIF input not taken from lane 2 pin");
    property p_rx_clk_in;
        (ctrl[CTRL_P3_EN] && !ctrl[CTRL_HCKR_OUT] && !rcs_pick) |=> port3_rx_clk_use_pin && !pin_oe[PIN_HCKR];
    endproperty
    a_rx_clk_in: assert property (p_rx_clk_in) else $error("receiver not clocked from pin");
    property p_rx_clk_out;
        (ctrl[CTRL_P3_EN] && ctrl[CTRL_HCKR_OUT] && !rcs_pick) |=>
            pin_oe[PIN_HCKR] && (pin_out[PIN_HCKR] == $past(port3_rx_hf_clk_src)) && !port3_rx_clk_use_pin;
    endproperty
    a_rx_clk_out: assert property (p_rx_clk_out) else $error("receive HF clock not driven");
    property p_tx_clk;
        (ctrl[CTRL_P3_EN] && !tcs_pick) |=> (port3_tx_clk_use_pin != pin_oe[PIN_HCKT]) &&
            (!pin_oe[PIN_HCKT] || pin_out[PIN_HCKT] == $past(port3_tx_hf_clk_src));
    endproperty
    a_tx_clk: assert property (p_tx_clk) else $error("transmit HF clock pin misrouted");
    property p_spd_rx_clock_out;
        rcs_pick |=> pin_oe[PIN_HCKR] && (pin_out[PIN_HCKR] == $past(spd_rx_clock_out)) && !port3_rx_clk_use_pin;
    endproperty
    a_spd_rx_clock_out: assert property (p_spd_rx_clock_out) else $error("recovered clock not on receive HF pin");
    property p_spd_tx_clock_in;
        tcs_pick |=> !pin_oe[PIN_HCKT] && (spd_tx_clock_in == $past(pin_sync[PIN_HCKT])) && !port3_tx_clk_use_pin;
    endproperty
    a_spd_tx_clock_in: assert property (p_spd_tx_clock_in) else $error("S/PDIF transmit clock not from pin");
endmodule

/* apm_pad_model.sv */
`timescale 1ns/100ps
// ****************************************
// Board side of the pads
// ****************************************
module apm_pad_model
#(
    parameter logic [5:0] PULL = 6'h0F
)
(
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_val,
    input  wire logic [5:0] ext_en,
    output logic      [5:0] pin_in
);
    // Device drive, else board driver, else pull
    always_comb
    begin
        for (int i = 0; i < 6; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : PULL[i]);
    end
endmodule

/* apm_audio_pin_mux_tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s %0h %0h", n, e, g); end end
module apm_audio_pin_mux_tb_top;
    import apm_pkg::*;
    localparam logic [5:0]  PULL = 6'h0F;
    localparam logic [10:0] CORN [5] = '{11'h000, 11'h003, 11'h007, 11'h01F, 11'h2FF};
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, rx2, rx3, ruse, rext, tuse, t_ext, spi, stc;
    logic        tx3 = 0, tx2 = 0, rsrc = 0, tsrc = 0, spo = 0, srk = 0;
    logic [5:0]  pin_in, pin_out, pin_oe, ext_val = 6'h00, ext_en = 6'h00, oe, o, gin;
    logic [4:0]  ctrl;
    logic [3:0]  pmx;
    logic [1:0]  ph;
    logic [11:0] dir;
    logic [5:0]  gout;
    int          fails = 0, num_checks = 0, cycles = 0;

    apm_audio_pin_mux #(.SMALL_PKG(1'b1)) apm_audio_pin_mux_i
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pin_in, .pin_out, .pin_oe, .tx_shift_reg_3_bit(tx3), .tx_shift_reg_2_bit(tx2),
        .rx_shift_reg_2_bit(rx2), .rx_shift_reg_3_bit(rx3), .port3_rx_hf_clk_src(rsrc),
        .port3_tx_hf_clk_src(tsrc), .port3_rx_clk_use_pin(ruse), .port3_rx_ext_clk(rext),
        .port3_tx_clk_use_pin(tuse), .port3_tx_ext_clk(t_ext), .spd_output_line1(spo),
        .spd_input_line1(spi), .spd_rx_clock_out(srk), .spd_tx_clock_in(stc)
    );
    apm_pad_model #(.PULL(PULL)) apm_pad_model_i (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

    always #2 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fails++;
            print_verdict();
        end
    end

    // ****************************************
    // Bus, reset and expectation helpers
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    function automatic logic pad(int i);
        return ext_en[i] ? ext_val[i] : PULL[i];
    endfunction

    task automatic check_all();
        logic ur, ut;
        for (int i = 0; i < 6; i++)
            oe[i] = dir[2*i+:2] == 2'h2;
        o = oe & gout;
        if (ctrl[CTRL_P2_TX]) {oe[1:0], o[1:0]} = {2'h3, tx2, tx3};
        if (ctrl[CTRL_P2_RX]) {oe[3:2], o[3:2]} = 4'h0;
        if (ctrl[CTRL_P3_EN]) {oe[5:4], o[5:4]} = {ctrl[4:3], ctrl[4] & tsrc, ctrl[3] & rsrc};
        if (pmx[PMX_SPD_OUT_EN]) {oe[0], o[0]} = {1'b1, spo};
        if (pmx[PMX_SPD_IN1_EN]) {oe[1], o[1]} = 2'h0;
        if (pmx[3:2] == RCS_SPD) {oe[4], o[4]} = {1'b1, srk};
        if (ph == TCS_PIN) {oe[5], o[5]} = 2'h0;
        ur = ctrl[2] & ~ctrl[3] & (pmx[3:2] != RCS_SPD);
        ut = ctrl[2] & ~ctrl[4] & (ph != TCS_PIN);
        `CHK("pin_oe", oe, pin_oe)
        `CHK("pin_out", o, pin_out & pin_oe)
        `CHK("rx_lanes", {2{ctrl[1]}} & {pad(3), pad(2)}, {rx3, rx2})
        `CHK("spd_in", pmx[1] & pad(1), spi)
        `CHK("spd_tclk", (ph == TCS_PIN) & pad(5), stc)
        `CHK("rx_clk", {ur, ur & pad(4)}, {ruse, rext})
        `CHK("tx_clk", {ut, ut & pad(5)}, {tuse, t_ext})
    endtask

    task automatic print_verdict();
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(66));
        do_reset();
        @(negedge pclk);
        `CHK("reset_oe", 6'h00, pin_oe)
        apb(1'b0, OFF_ROLE, 32'h0);
        `CHK("reset_role", 32'h00009249, rd)
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped", 33'h100000000, {err, rd})
        for (int k = 0; k < 40; k++)
        begin
            {ph, pmx, ctrl} = (k < 5) ? CORN[k] : (k % 8 == 0) ? 11'h000 : 11'($urandom);
            dir = 12'($urandom);
            gout = 6'($urandom);
            {tx3, tx2, rsrc, tsrc, spo, srk, ext_val, ext_en} <= 18'($urandom);
            apb(1'b1, OFF_CTRL, 32'(ctrl));
            apb(1'b1, OFF_PINMUX, 32'(pmx));
            apb(1'b1, OFF_SPD_PHASE, 32'(ph));
            apb(1'b1, OFF_GPIO_DIR, 32'(dir));
            apb(1'b1, OFF_GPIO_OUT, 32'(gout));
            repeat (4) @(posedge pclk);
            @(negedge pclk);
            check_all();
            apb(1'b0, OFF_CTRL, 32'h0);
            `CHK("ctrl_rd", {27'h0, ctrl}, rd)
            if ({ph, pmx, ctrl} == 11'h000)
            begin
                apb(1'b0, OFF_GPIO_IN, 32'h0);
                for (int i = 0; i < 6; i++)
                    gin[i] = (dir[2*i+:2] == 2'h1) & pad(i);
                `CHK("gpio_in", {26'h0, gin}, rd)
            end
        end
        do_reset();
        {ph, pmx, ctrl, dir, gout} = '0;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        check_all();
        print_verdict();
    end
endmodule
